//--- pkg/mtr_pkg.sv
// Purpose: constants and types for the bus protocol trigger matcher
// Assumes: words arrive already decoded, one strobe per word
// Notes:   settings are plain ports; defaults are the settings-reset values
// How it works
// - trigger type picks sync, frame, error, command, status or data; sync after reset.
// - command type selects addressed word or mode code; addressed word after reset.
// - data value compared by eight relational or range tests; off after reset.
// - data compared against min and max patterns with per-bit don't-care.
// - data offset selects word position in message; zero after reset.
// - offset qualified by six relational tests only, no range tests.
// - count of consecutive data words compared; one after reset.
// - error mode fires on Manchester violation when enabled; enabled after reset.
// - error mode fires on even parity word when enabled; enabled after reset.
// - error mode fires on bad sync or invalid transmission when enabled.
// - error mode fires when measured timeout cmp_range_a configured range, if enabled.
// - mode code function matches one of thirty-one or any; any after reset.
// - mode code field must equal held mode code value when the function is any.
// - terminal address compared by eight tests with don't-care patterns; off after reset.
// - subaddress compared by eight tests with don't-care patterns; off after reset.
// - mode code subaddress matches zero, top or either; either after reset.
// - eight status flags each match 0, 1 or don't-care; all don't-care after reset.
// - sync mode fires on command/status, data or either sync; command/status after reset.
// - command direction matches transmit, receive or either; either after reset.
// - transfer kind selectable among four; controller-to-terminal after reset.
// - word count compared by eight tests against min and max; off after reset.
// - bus polarity positive or negative; positive after reset.
// - min and max response limits, max may be unbounded, define timeout range.
package mtr_pkg;
  typedef enum logic [2:0] {
    MTR_TRG_SYNC   = 3'h0,
    MTR_TRG_FRAME  = 3'h1,
    MTR_TRG_ERROR  = 3'h2,
    MTR_TRG_CMD    = 3'h3,
    MTR_TRG_STATUS = 3'h4,
    MTR_TRG_DATA   = 3'h5
  } mtr_trg_t;

  typedef enum logic [3:0] {
    MTR_CMP_OFF          = 4'h0,
    MTR_CMP_EQUAL        = 4'h1,
    MTR_CMP_NOT_EQUAL    = 4'h2,
    MTR_CMP_GREATER      = 4'h3,
    MTR_CMP_GREATER_OR_EQ = 4'h4,
    MTR_CMP_LESS_OR_EQ   = 4'h5,
    MTR_CMP_LESS         = 4'h6,
    MTR_CMP_INSIDE_RANGE = 4'h7,
    MTR_CMP_CMP_RANGE_A_RANGE = 4'h8
  } mtr_cmp_t;

  typedef enum logic [1:0] {
    MTR_SEL_FIRST  = 2'h0,
    MTR_SEL_SECOND = 2'h1,
    MTR_SEL_EITHER = 2'h2
  } mtr_sel3_t;

  typedef enum logic [1:0] {
    MTR_XFER_CONTROLLER_TO_TERMINAL = 2'h0,
    MTR_XFER_TERMINAL_TO_CONTROLLER = 2'h1,
    MTR_XFER_TERMINAL_TO_TERMINAL   = 2'h2,
    MTR_XFER_MODE_CODE_WITH_DATA    = 2'h3
  } mtr_xfer_t;

  typedef enum logic [1:0] {
    MTR_ST_IDLE = 2'h0,
    MTR_ST_CMD  = 2'h1,
    MTR_ST_DATA = 2'h2
  } mtr_state_t;

  localparam logic [4:0]  MTR_FN_ANY          = 5'h1f;
  localparam logic [4:0]  MTR_SUBADDR_ZERO    = 5'h00;
  localparam logic [4:0]  MTR_SUBADDR_TOP     = 5'h1f;
  localparam logic [5:0]  MTR_OFFSET_RST      = 6'h00;
  localparam logic [5:0]  MTR_WORDS_RST       = 6'h01;
  localparam int          MTR_RT_POS          = 11;
  localparam int          MTR_TR_POS          = 10;
  localparam int          MTR_SA_POS          = 5;
  localparam int          MTR_WC_POS          = 0;
  localparam logic [4:0]  MTR_WC_ZERO_MEANS   = 5'h00;
  localparam logic [6:0]  MTR_WC_FULL         = 7'h20;
endpackage : mtr_pkg

//--- src/mtr_field_cmp.sv
`timescale 1ns/1ps
// Purpose: one field comparator, relational or range, with don't-care bits
// Assumes: compare code from the package
// Notes:   care bits masked on both sides before compare
module mtr_field_cmp
  import mtr_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] min_val_i,
  input  wire logic [W-1:0] min_care_i,
  input  wire logic [W-1:0] max_val_i,
  input  wire logic [W-1:0] max_care_i,
  input  wire logic [3:0]   cond_i,
  output logic              match_o
);
  logic [W-1:0] v_lo;
  logic [W-1:0] p_lo;
  logic [W-1:0] v_hi;
  logic [W-1:0] p_hi;

  // don't-care bits forced equal on both sides
  assign v_lo = value_i & min_care_i;
  assign p_lo = min_val_i & min_care_i;
  assign v_hi = value_i & max_care_i;
  assign p_hi = max_val_i & max_care_i;

  always_comb begin
    case (mtr_cmp_t'(cond_i))
      MTR_CMP_OFF:           match_o = 1'b1;
      MTR_CMP_EQUAL:         match_o = (v_lo == p_lo);
      MTR_CMP_NOT_EQUAL:     match_o = (v_lo != p_lo);
      MTR_CMP_GREATER:       match_o = (v_lo > p_lo);
      MTR_CMP_GREATER_OR_EQ: match_o = (v_lo >= p_lo);
      MTR_CMP_LESS_OR_EQ:    match_o = (v_lo <= p_lo);
      MTR_CMP_LESS:          match_o = (v_lo < p_lo);
      MTR_CMP_INSIDE_RANGE:  match_o = (v_lo >= p_lo) && (v_hi <= p_hi);
      MTR_CMP_CMP_RANGE_A_RANGE: match_o = (v_lo < p_lo) || (v_hi > p_hi);
      default:               match_o = 1'b0;
    endcase
  end
endmodule : mtr_field_cmp

//--- src/mtr_trigger.sv
`timescale 1ns/1ps
// Purpose: protocol trigger matcher on a decoded serial command/response bus
// Assumes: one word strobe per decoded word with sync kind and error flags
// Notes:   settings ports are live; TRIG_O is a one-cycle pulse
module mtr_trigger
  import mtr_pkg::*;
#(
  parameter int TW = 16
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  input  wire logic          WORD_VALID_I,
  input  wire logic [15:0]   WORD_DATA_I,
  input  wire logic          WORD_CMD_SYNC_I,
  input  wire logic          WORD_PARITY_I,
  input  wire logic          MANCH_ERR_I,
  input  wire logic          SYNC_ERR_I,
  input  wire logic          FRAME_START_I,
  input  wire logic          RESP_VALID_I,
  input  wire logic [TW-1:0] RESP_TIME_I,
  input  wire logic [2:0]    TRIG_TYPE_I,
  input  wire logic          CMD_MODE_CODE_I,
  input  wire logic          BUS_NEGATIVE_I,
  input  wire logic [1:0]    SYNC_SEL_I,
  input  wire logic [1:0]    TRANSFER_DIRECTION_I,
  input  wire logic [1:0]    TRANSFER_KIND_I,
  input  wire logic [3:0]    DATA_COND_I,
  input  wire logic [15:0]   DATA_MIN_I,
  input  wire logic [15:0]   DATA_MIN_CARE_I,
  input  wire logic [15:0]   DATA_MAX_I,
  input  wire logic [15:0]   DATA_MAX_CARE_I,
  input  wire logic [5:0]    DATA_OFFSET_I,
  input  wire logic [3:0]    OFFSET_COND_I,
  input  wire logic [5:0]    DATA_WORDS_I,
  input  wire logic          ERR_MANCH_EN_I,
  input  wire logic          ERR_PARITY_EN_I,
  input  wire logic          ERR_SYNC_EN_I,
  input  wire logic          ERR_TIMEOUT_EN_I,
  input  wire logic [TW-1:0] RESP_MIN_I,
  input  wire logic [TW-1:0] RESP_MAX_I,
  input  wire logic          RESP_MAX_UNBOUNDED_I,
  input  wire logic [4:0]    MODE_FN_I,
  input  wire logic [4:0]    MODE_VALUE_I,
  input  wire logic [1:0]    MODE_SUBADDR_SEL_I,
  input  wire logic [3:0]    ADDR_COND_I,
  input  wire logic [4:0]    ADDR_MIN_I,
  input  wire logic [4:0]    ADDR_MIN_CARE_I,
  input  wire logic [4:0]    ADDR_MAX_I,
  input  wire logic [4:0]    ADDR_MAX_CARE_I,
  input  wire logic [3:0]    SUBADDR_COND_I,
  input  wire logic [4:0]    SUBADDR_MIN_I,
  input  wire logic [4:0]    SUBADDR_MIN_CARE_I,
  input  wire logic [4:0]    SUBADDR_MAX_I,
  input  wire logic [4:0]    SUBADDR_MAX_CARE_I,
  input  wire logic [3:0]    WORD_COUNT_FIELD_COND_I,
  input  wire logic [4:0]    WORD_COUNT_FIELD_MIN_I,
  input  wire logic [4:0]    WORD_COUNT_FIELD_MAX_I,
  input  wire logic [7:0]    STATUS_VAL_I,
  input  wire logic [7:0]    STATUS_CARE_I,
  output logic               TRIG_O,
  output logic               ERR_SEEN_O,
  output logic [5:0]         WORD_POS_O
);

  // ------------------------------------------------------------------
  // word decode
  // ------------------------------------------------------------------
  logic        cmd_sync;
  logic        odd_ok;
  logic [4:0]  f_rt;
  logic        f_tr;
  logic [4:0]  f_sa;
  logic [4:0]  f_wc;
  logic [7:0]  f_status;
  logic        is_mode;

  // negative polarity swaps the sync kinds
  assign cmd_sync = WORD_CMD_SYNC_I ^ BUS_NEGATIVE_I;
  assign odd_ok   = ^{WORD_DATA_I, WORD_PARITY_I};
  assign f_rt     = WORD_DATA_I[MTR_RT_POS +: 5];
  assign f_tr     = WORD_DATA_I[MTR_TR_POS];
  assign f_sa     = WORD_DATA_I[MTR_SA_POS +: 5];
  assign f_wc     = WORD_DATA_I[MTR_WC_POS +: 5];
  assign is_mode  = (f_sa == MTR_SUBADDR_ZERO) || (f_sa == MTR_SUBADDR_TOP);
  // broadcast, busy, bus-accept, instr, msg err, svc req, subsys, terminal
  assign f_status = {WORD_DATA_I[9], WORD_DATA_I[8], WORD_DATA_I[1],
                     WORD_DATA_I[4], WORD_DATA_I[10], WORD_DATA_I[8-0],
                     WORD_DATA_I[2], WORD_DATA_I[0]};

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic sel3(input logic [1:0] sel, input logic a, input logic b);
    case (mtr_sel3_t'(sel))
      MTR_SEL_FIRST:  sel3 = a;
      MTR_SEL_SECOND: sel3 = b;
      MTR_SEL_EITHER: sel3 = a | b;
      default:        sel3 = 1'b0;
    endcase
  endfunction : sel3

  function automatic logic rel6(input logic [3:0] c, input logic [5:0] v,
                                input logic [5:0] p);
    case (mtr_cmp_t'(c))
      MTR_CMP_OFF:           rel6 = (v == p);
      MTR_CMP_EQUAL:         rel6 = (v == p);
      MTR_CMP_NOT_EQUAL:     rel6 = (v != p);
      MTR_CMP_GREATER:       rel6 = (v > p);
      MTR_CMP_GREATER_OR_EQ: rel6 = (v >= p);
      MTR_CMP_LESS_OR_EQ:    rel6 = (v <= p);
      MTR_CMP_LESS:          rel6 = (v < p);
      default:               rel6 = (v == p);
    endcase
  endfunction : rel6

  // ------------------------------------------------------------------
  // field comparators
  // ------------------------------------------------------------------
  logic m_rt;
  logic m_sa;
  logic m_wc;
  logic m_data;

  mtr_field_cmp #(.W(5)) u_rt (
    .value_i    (f_rt),
    .min_val_i  (ADDR_MIN_I),
    .min_care_i (ADDR_MIN_CARE_I),
    .max_val_i  (ADDR_MAX_I),
    .max_care_i (ADDR_MAX_CARE_I),
    .cond_i     (ADDR_COND_I),
    .match_o    (m_rt)
  );

  mtr_field_cmp #(.W(5)) u_sa (
    .value_i    (f_sa),
    .min_val_i  (SUBADDR_MIN_I),
    .min_care_i (SUBADDR_MIN_CARE_I),
    .max_val_i  (SUBADDR_MAX_I),
    .max_care_i (SUBADDR_MAX_CARE_I),
    .cond_i     (SUBADDR_COND_I),
    .match_o    (m_sa)
  );

  mtr_field_cmp #(.W(5)) u_wc (
    .value_i    (f_wc),
    .min_val_i  (WORD_COUNT_FIELD_MIN_I),
    .min_care_i (5'h1f),
    .max_val_i  (WORD_COUNT_FIELD_MAX_I),
    .max_care_i (5'h1f),
    .cond_i     (WORD_COUNT_FIELD_COND_I),
    .match_o    (m_wc)
  );

  mtr_field_cmp #(.W(16)) u_data (
    .value_i    (WORD_DATA_I),
    .min_val_i  (DATA_MIN_I),
    .min_care_i (DATA_MIN_CARE_I),
    .max_val_i  (DATA_MAX_I),
    .max_care_i (DATA_MAX_CARE_I),
    .cond_i     (DATA_COND_I),
    .match_o    (m_data)
  );

  // ------------------------------------------------------------------
  // command word qualification
  // ------------------------------------------------------------------
  logic m_dir;
  logic m_kind;
  logic m_mode;
  logic m_cmd;

  assign m_dir = sel3(TRANSFER_DIRECTION_I, f_tr, ~f_tr);

  always_comb begin
    case (mtr_xfer_t'(TRANSFER_KIND_I))
      MTR_XFER_CONTROLLER_TO_TERMINAL: m_kind = ~f_tr && !is_mode;
      MTR_XFER_TERMINAL_TO_CONTROLLER: m_kind = f_tr && !is_mode;
      MTR_XFER_TERMINAL_TO_TERMINAL:   m_kind = !is_mode;
      MTR_XFER_MODE_CODE_WITH_DATA:    m_kind = is_mode && f_wc[4];
      default:                         m_kind = 1'b0;
    endcase
  end

  // mode code field sits in the word-count position
  assign m_mode = is_mode
                && sel3(MODE_SUBADDR_SEL_I, f_sa == MTR_SUBADDR_ZERO,
                        f_sa == MTR_SUBADDR_TOP)
                && ((MODE_FN_I == MTR_FN_ANY) || (f_wc == MODE_FN_I))
                && (f_wc == MODE_VALUE_I || MODE_FN_I != MTR_FN_ANY);

  assign m_cmd = m_rt && m_dir
               && (CMD_MODE_CODE_I ? m_mode : (m_sa && m_wc && m_kind));

  // ------------------------------------------------------------------
  // message tracking
  // ------------------------------------------------------------------
  mtr_state_t state;
  mtr_state_t next_state;
  logic [5:0] pos;
  logic [5:0] run;

  always_comb begin
    case (state)
      MTR_ST_IDLE: next_state = (WORD_VALID_I && cmd_sync) ? MTR_ST_CMD : MTR_ST_IDLE;
      MTR_ST_CMD:  next_state = (WORD_VALID_I && !cmd_sync) ? MTR_ST_DATA : state;
      MTR_ST_DATA: next_state = (WORD_VALID_I && cmd_sync) ? MTR_ST_CMD : state;
      default:     next_state = MTR_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= MTR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // data word position cmp_inside_range message
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pos <= MTR_OFFSET_RST;
    end else if (WORD_VALID_I) begin
      pos <= cmd_sync ? MTR_OFFSET_RST : pos + 6'h01;
    end
  end

  // run of consecutive matching data words at a qualified offset
  logic data_hit;
  logic at_offset;
  assign at_offset = rel6(OFFSET_COND_I, pos, DATA_OFFSET_I);
  assign data_hit  = WORD_VALID_I && !cmd_sync && m_data
                   && (state != MTR_ST_IDLE) && (at_offset || run != 6'h00);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      run <= 6'h00;
    end else if (WORD_VALID_I) begin
      if (data_hit && (run + 6'h01) < DATA_WORDS_I) begin
        run <= run + 6'h01;
      end else begin
        run <= 6'h00;
      end
    end
  end

  // ------------------------------------------------------------------
  // errors
  // ------------------------------------------------------------------
  logic e_manch;
  logic e_par;
  logic e_sync;
  logic e_to;
  logic any_err;

  assign e_manch = ERR_MANCH_EN_I && WORD_VALID_I && MANCH_ERR_I;
  assign e_par   = ERR_PARITY_EN_I && WORD_VALID_I && !odd_ok;
  assign e_sync  = ERR_SYNC_EN_I && WORD_VALID_I && SYNC_ERR_I;
  assign e_to    = ERR_TIMEOUT_EN_I && RESP_VALID_I
                 && ((RESP_TIME_I < RESP_MIN_I)
                  || (!RESP_MAX_UNBOUNDED_I && RESP_TIME_I > RESP_MAX_I));
  assign any_err = e_manch | e_par | e_sync | e_to;

  // ------------------------------------------------------------------
  // trigger selection
  // ------------------------------------------------------------------
  logic next_trig;

  always_comb begin
    case (mtr_trg_t'(TRIG_TYPE_I))
      MTR_TRG_SYNC:   next_trig = WORD_VALID_I
                                  && sel3(SYNC_SEL_I, cmd_sync, !cmd_sync);
      MTR_TRG_FRAME:  next_trig = FRAME_START_I;
      MTR_TRG_ERROR:  next_trig = any_err;
      MTR_TRG_CMD:    next_trig = WORD_VALID_I && cmd_sync && m_cmd;
      MTR_TRG_STATUS: next_trig = WORD_VALID_I && cmd_sync
                                  && (((f_status ^ STATUS_VAL_I) & STATUS_CARE_I) == 8'h00);
      MTR_TRG_DATA:   next_trig = data_hit && (run + 6'h01) >= DATA_WORDS_I;
      default:        next_trig = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TRIG_O <= 1'b0;
    end else begin
      TRIG_O <= next_trig;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ERR_SEEN_O <= 1'b0;
    end else begin
      ERR_SEEN_O <= any_err;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WORD_POS_O <= MTR_OFFSET_RST;
    end else begin
      WORD_POS_O <= pos;
    end
  end
endmodule : mtr_trigger

//--- tb/mtr_trigger_chk.sv
// Purpose: port checks for the trigger matcher
// Assumes: one clock domain, async active-high reset
// Notes:   bound to every matcher instance
`timescale 1ns/1ps
module mtr_trigger_chk
  import mtr_pkg::*;
#(
  parameter int TW = 16
) (
  input wire logic          CLK_I,
  input wire logic          RST_I,
  input wire logic          WORD_VALID_I,
  input wire logic [15:0]   WORD_DATA_I,
  input wire logic          WORD_CMD_SYNC_I,
  input wire logic          WORD_PARITY_I,
  input wire logic          MANCH_ERR_I,
  input wire logic          SYNC_ERR_I,
  input wire logic          FRAME_START_I,
  input wire logic          RESP_VALID_I,
  input wire logic [TW-1:0] RESP_TIME_I,
  input wire logic [2:0]    TRIG_TYPE_I,
  input wire logic          BUS_NEGATIVE_I,
  input wire logic [1:0]    SYNC_SEL_I,
  input wire logic          ERR_MANCH_EN_I,
  input wire logic          ERR_PARITY_EN_I,
  input wire logic          ERR_TIMEOUT_EN_I,
  input wire logic [TW-1:0] RESP_MIN_I,
  input wire logic          TRIG_O,
  input wire logic [5:0]    WORD_POS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic clean;
  // a word with no error of any class
  assign clean = WORD_VALID_I && !MANCH_ERR_I && !SYNC_ERR_I && ^{WORD_DATA_I, WORD_PARITY_I};
  a_trig_has_cause: assert property (
    TRIG_O |-> $past(WORD_VALID_I | FRAME_START_I | RESP_VALID_I))
    else $error("trigger without a qualifying input");
  a_frame_fires: assert property (
    TRIG_TYPE_I == MTR_TRG_FRAME && FRAME_START_I |=> TRIG_O)
    else $error("frame start gave no trigger");
  a_cmd_sync_fires: assert property (
    TRIG_TYPE_I == MTR_TRG_SYNC && SYNC_SEL_I == 2'h0 && !BUS_NEGATIVE_I && clean
    && WORD_CMD_SYNC_I |=> TRIG_O) else $error("command sync gave no trigger");
  a_data_sync_quiet: assert property (
    TRIG_TYPE_I == MTR_TRG_SYNC && SYNC_SEL_I == 2'h1 && !BUS_NEGATIVE_I && clean
    && WORD_CMD_SYNC_I |=> !TRIG_O) else $error("data sync select fired on command sync");
  a_neg_swaps_kind: assert property (
    TRIG_TYPE_I == MTR_TRG_SYNC && SYNC_SEL_I == 2'h0 && BUS_NEGATIVE_I && clean
    && !WORD_CMD_SYNC_I |=> TRIG_O) else $error("negative polarity not applied");
  a_manch_fires: assert property (
    TRIG_TYPE_I == MTR_TRG_ERROR && WORD_VALID_I && MANCH_ERR_I && ERR_MANCH_EN_I |=> TRIG_O)
    else $error("coding error gave no trigger");
  a_parity_fires: assert property (
    TRIG_TYPE_I == MTR_TRG_ERROR && WORD_VALID_I && ERR_PARITY_EN_I
    && !(^{WORD_DATA_I, WORD_PARITY_I}) |=> TRIG_O) else $error("even parity gave no trigger");
  a_clean_quiet: assert property (
    TRIG_TYPE_I == MTR_TRG_ERROR && clean && !RESP_VALID_I |=> !TRIG_O)
    else $error("error trigger on a clean word");
  a_timeout_low: assert property (
    TRIG_TYPE_I == MTR_TRG_ERROR && ERR_TIMEOUT_EN_I && RESP_VALID_I
    && RESP_TIME_I < RESP_MIN_I |=> TRIG_O) else $error("short response gave no trigger");
  a_pos_restart: assert property (
    clean && WORD_CMD_SYNC_I && !BUS_NEGATIVE_I |-> ##2 WORD_POS_O == 6'h00)
    else $error("position not cleared on command word");
  a_pos_steps: assert property (
    clean && !WORD_CMD_SYNC_I && !BUS_NEGATIVE_I |-> ##2 WORD_POS_O == $past(WORD_POS_O) + 6'h01)
    else $error("position not advanced on data word");
endmodule : mtr_trigger_chk

bind mtr_trigger mtr_trigger_chk #(.TW(TW)) chk_u (
  .CLK_I, .RST_I, .WORD_VALID_I, .WORD_DATA_I, .WORD_CMD_SYNC_I, .WORD_PARITY_I,
  .MANCH_ERR_I, .SYNC_ERR_I, .FRAME_START_I, .RESP_VALID_I, .RESP_TIME_I, .TRIG_TYPE_I,
  .BUS_NEGATIVE_I, .SYNC_SEL_I, .ERR_MANCH_EN_I, .ERR_PARITY_EN_I, .ERR_TIMEOUT_EN_I,
  .RESP_MIN_I, .TRIG_O, .WORD_POS_O
);

//--- tb/mtr_bus_model.sv
// Purpose: decoded bus under test, one word or event per call
// Assumes: calls start just after a falling edge
// Notes:   released data, sync and response-time lines show the inverse of the last value; parity is kept
`timescale 1ns/1ps
module mtr_bus_model (
  input  wire logic   clk_i,
  output logic        word_valid_o,
  output logic [15:0] word_data_o,
  output logic        cmd_sync_o,
  output logic        parity_o,
  output logic        manch_err_o,
  output logic        sync_err_o,
  output logic        frame_start_o,
  output logic        resp_valid_o,
  output logic [15:0] resp_time_o
);
  initial begin
    {word_valid_o, word_data_o, cmd_sync_o, parity_o, manch_err_o, sync_err_o} = '0;
    {frame_start_o, resp_valid_o, resp_time_o} = '0;
  end
  // e: bit 0 breaks parity, bit 1 coding error, bit 2 sync error
  task automatic send(input logic [15:0] d, input logic c, input logic [2:0] e);
    word_data_o  = d;
    cmd_sync_o   = c;
    parity_o     = ~^d ^ e[0];
    manch_err_o  = e[1];
    sync_err_o   = e[2];
    word_valid_o = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    {word_valid_o, manch_err_o, sync_err_o} = 3'h0;
    word_data_o  = ~d;
    cmd_sync_o   = ~c;
  endtask : send
  task automatic side(input logic f, input logic r, input logic [15:0] t);
    frame_start_o = f;
    resp_valid_o  = r;
    resp_time_o   = t;
    @(posedge clk_i);
    @(negedge clk_i);
    {frame_start_o, resp_valid_o} = 2'h0;
    resp_time_o   = ~t;
  endtask : side
endmodule : mtr_bus_model

//--- tb/mtr_trigger_tb.sv
// Purpose: self-checking bench for the trigger matcher
// Assumes: settings held by the bench, words from the bus model
// Notes:   random stimulus from a fixed seed
`timescale 1ns/1ps
module mtr_trigger_tb
  import mtr_pkg::*;
;
  logic        clk, rst, wv, wcs, wpar, merr, serr, fs, rv, trig, err_seen;
  logic        cmd_mode, bus_neg, en_manch, en_par, en_sync, en_tmo, resp_unb;
  logic [15:0] wd, rt, d_min, d_min_c, d_max, d_max_c, resp_min, resp_max, v;
  logic [5:0]  pos, d_off, d_words;
  logic [4:0]  m_fn, m_val, a_min, a_min_c, a_max, a_max_c, s_min, s_min_c, s_max, s_max_c;
  logic [4:0]  wc_min, wc_max, ra;
  logic [3:0]  d_cond, o_cond, a_cond, s_cond, wc_cond;
  logic [2:0]  trig_type, seq;
  logic [1:0]  sync_sel, dir, kind, msa_sel;
  logic [7:0]  st_val, st_care;
  int          err_count, total_checks;
  int unsigned seed_v;

  mtr_bus_model bus_u (.clk_i(clk), .word_valid_o(wv), .word_data_o(wd), .cmd_sync_o(wcs),
    .parity_o(wpar), .manch_err_o(merr), .sync_err_o(serr), .frame_start_o(fs),
    .resp_valid_o(rv), .resp_time_o(rt));
  mtr_trigger dut_u (.CLK_I(clk), .RST_I(rst), .WORD_VALID_I(wv), .WORD_DATA_I(wd),
    .WORD_CMD_SYNC_I(wcs), .WORD_PARITY_I(wpar), .MANCH_ERR_I(merr), .SYNC_ERR_I(serr),
    .FRAME_START_I(fs), .RESP_VALID_I(rv), .RESP_TIME_I(rt), .TRIG_TYPE_I(trig_type),
    .CMD_MODE_CODE_I(cmd_mode), .BUS_NEGATIVE_I(bus_neg), .SYNC_SEL_I(sync_sel),
    .TRANSFER_DIRECTION_I(dir), .TRANSFER_KIND_I(kind), .DATA_COND_I(d_cond),
    .DATA_MIN_I(d_min), .DATA_MIN_CARE_I(d_min_c), .DATA_MAX_I(d_max),
    .DATA_MAX_CARE_I(d_max_c), .DATA_OFFSET_I(d_off), .OFFSET_COND_I(o_cond),
    .DATA_WORDS_I(d_words), .ERR_MANCH_EN_I(en_manch), .ERR_PARITY_EN_I(en_par),
    .ERR_SYNC_EN_I(en_sync), .ERR_TIMEOUT_EN_I(en_tmo), .RESP_MIN_I(resp_min),
    .RESP_MAX_I(resp_max), .RESP_MAX_UNBOUNDED_I(resp_unb), .MODE_FN_I(m_fn),
    .MODE_VALUE_I(m_val), .MODE_SUBADDR_SEL_I(msa_sel), .ADDR_COND_I(a_cond),
    .ADDR_MIN_I(a_min), .ADDR_MIN_CARE_I(a_min_c), .ADDR_MAX_I(a_max),
    .ADDR_MAX_CARE_I(a_max_c), .SUBADDR_COND_I(s_cond), .SUBADDR_MIN_I(s_min),
    .SUBADDR_MIN_CARE_I(s_min_c), .SUBADDR_MAX_I(s_max), .SUBADDR_MAX_CARE_I(s_max_c),
    .WORD_COUNT_FIELD_COND_I(wc_cond), .WORD_COUNT_FIELD_MIN_I(wc_min), .WORD_COUNT_FIELD_MAX_I(wc_max),
    .STATUS_VAL_I(st_val), .STATUS_CARE_I(st_care), .TRIG_O(trig), .ERR_SEEN_O(err_seen),
    .WORD_POS_O(pos));

  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic cmp_exp(input logic [3:0] c, input logic [15:0] x, lo, hi, lc, hc);
    logic [15:0] a, b, m, n;
    a = x & lc;
    b = lo & lc;
    m = x & hc;
    n = hi & hc;
    case (c)
      4'h1: return a == b;
      4'h2: return a != b;
      4'h3: return a > b;
      4'h4: return a >= b;
      4'h5: return a <= b;
      4'h6: return a < b;
      4'h7: return a >= b && m <= n;
      4'h8: return a < b || m > n;
      default: return 1'b1;
    endcase
  endfunction : cmp_exp
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_pos(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pos
  task automatic xfer(input logic [15:0] d, input logic c, input logic [2:0] e);
    @(negedge clk);
    bus_u.send(d, c, e);
  endtask : xfer
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #60us;
    err_count++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {trig_type, cmd_mode, bus_neg, sync_sel, kind, d_cond, o_cond, wc_cond} = '0;
    {a_cond, s_cond, d_off, resp_unb, st_val, st_care, m_val, wc_min, wc_max} = '0;
    {dir, msa_sel, m_fn, d_words} = {2'h2, 2'h2, 5'h1f, 6'h01};
    {en_manch, en_par, en_sync, en_tmo} = 4'hf;
    {d_min, d_max, d_min_c, d_max_c} = {32'h0, 32'hffff_ffff};
    {a_min, a_max, a_min_c, a_max_c} = {10'h0, 10'h3ff};
    {s_min, s_max, s_min_c, s_max_c} = {10'h0, 10'h3ff};
    {resp_min, resp_max} = {16'h0100, 16'h0200};
    seed_v = $urandom(71201);
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 112; i++) begin
      seq = (i < 12) ? 3'(i) : 3'($urandom_range(7));
      sync_sel = (i < 12) ? 2'(i / 4) : 2'($urandom_range(2));
      bus_neg = seq[1];
      xfer(16'($urandom), seq[0], 3'h0);
      chk_bit(trig, sync_sel == 2'h2 || ((seq[0] ^ seq[1]) == (sync_sel == 2'h0)));
    end
    {bus_neg, trig_type} = {1'b0, 3'h1};
    @(negedge clk);
    bus_u.side(1'b1, 1'b0, 16'h0);
    chk_bit(trig, 1'b1);
    xfer(16'h0821, 1'b1, 3'h0);
    chk_bit(trig, 1'b0);
    trig_type = 3'h2;
    for (int k = 0; k < 8; k++) begin
      {en_tmo, en_sync, en_manch, en_par} = 4'(k[0]) << k[2:1];
      @(negedge clk);
      if (k[2:1] == 2'h3) bus_u.side(1'b0, 1'b1, 16'h00ff);
      else bus_u.send(16'($urandom), 1'b0, 3'h1 << k[2:1]);
      chk_bit(trig, k[0]);
      chk_bit(err_seen, k[0]);
    end
    {en_manch, en_par, en_sync, en_tmo} = 4'hf;
    for (int j = 0; j < 4; j++) begin
      resp_unb = j[0];
      @(negedge clk);
      bus_u.side(1'b0, 1'b1, (j == 0) ? 16'h0150 : (j == 3) ? 16'h00ff : 16'h0300);
      chk_bit(trig, j >= 2);
    end
    xfer(16'h1234, 1'b0, 3'h0);
    chk_bit(trig, 1'b0);
    xfer(16'h1234, 1'b0, 3'h3);
    chk_bit(trig, 1'b1);
    {trig_type, d_min, d_max} = {3'h5, 16'h1232, 16'h1235};
    for (int i = 0; i < 48; i++) begin
      v = 16'h1230 + 16'($urandom_range(7));
      {d_cond, d_min_c} = {4'($urandom_range(8)), 16'hffff};
      if (i == 0) {d_cond, d_min_c} = {4'h1, 16'h0000};
      if (i == 1) {d_cond, v} = {4'h7, 16'h1235};
      if (i == 2) {d_cond, v} = {4'h8, 16'h1232};
      xfer(16'h0821, 1'b1, 3'h0);
      @(negedge clk);
      chk_pos(pos, 6'h00);
      xfer(v, 1'b0, 3'h0);
      chk_bit(trig, cmp_exp(d_cond, v, d_min, d_max, d_min_c, d_max_c));
      @(negedge clk);
      chk_pos(pos, 6'h01);
    end
    d_cond = 4'h0;
    for (int j = 0; j < 3; j++) begin
      {d_off, o_cond, d_words, seq} = (j == 0) ? {6'h02, 4'h1, 6'h01, 3'b001} :
        (j == 1) ? {6'h00, 4'h1, 6'h02, 3'b010} : {6'h01, 4'h6, 6'h01, 3'b100};
      xfer(16'h0821, 1'b1, 3'h0);
      for (int w = 0; w < 3; w++) begin
        xfer(16'($urandom), 1'b0, 3'h0);
        chk_bit(trig, seq[2 - w]);
      end
    end
    {trig_type, a_min, a_max} = {3'h3, 5'h0c, 5'h13};
    for (int i = 0; i < 24; i++) begin
      {a_cond, ra} = {4'($urandom_range(8)), 5'($urandom)};
      xfer({ra, 1'b0, 5'h01, 5'h02}, 1'b1, 3'h0);
      chk_bit(trig, cmp_exp(a_cond, 16'(ra), 16'h000c, 16'h0013, 16'h001f, 16'h001f));
    end
    {cmd_mode, a_cond, m_val} = {1'b1, 4'h0, 5'h02};
    xfer(16'h0be2, 1'b1, 3'h0);
    chk_bit(trig, 1'b1);
    xfer(16'h0be3, 1'b1, 3'h0);
    chk_bit(trig, 1'b0);
    {trig_type, st_care, st_val} = {3'h4, 8'h80, 8'h80};
    xfer(16'h0200, 1'b1, 3'h0);
    chk_bit(trig, 1'b1);
    xfer(16'h0000, 1'b1, 3'h0);
    chk_bit(trig, 1'b0);
    stop_test();
  end
endmodule : mtr_trigger_tb
